// file: rtl/cecat_alcap.sv
// arbitration-lost position capture, held until the flag is acknowledged
`timescale 1ns/1ps
`include "cecat_regs.svh"
module cecat_alcap (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic arb_lost,
  input wire logic [5:0] arb_pos,
  input wire logic flag_clr,
  output logic flag,
  output logic [5:0] pos
);
  wire take = arb_lost && !flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
      pos <= `CECAT_ALPOS_RESET;
    end else if (ce) begin
      // hold until acknowledged; a loss in the clear cycle wins
      if (arb_lost) begin
        flag <= 1'b1;
      end else if (flag_clr) begin
        flag <= 1'b0;
      end
      if (take) begin
        pos <= arb_pos;
      end
    end
  end
  alpos_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(flag) && flag && $past(ce) |-> pos == $past(pos)) else $error("arbitration position changed while held");
endmodule // cecat_alcap

// file: rtl/cecat_core.sv
// error counters, arbitration-lost capture and nominal timing register with APB access
`timescale 1ns/1ps
`include "cecat_regs.svh"
module cecat_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cecat_pkg::cecat_fc_ev_t fc_ev,
  input wire logic arb_lost,
  input wire logic [5:0] arb_pos,
  input wire logic fd_frame,
  input wire logic extended_timing_select,
  output cecat_pkg::cecat_timing_t nom_timing,
  output logic bus_off_flag,
  output logic arbitration_lost_flag,
  output logic rx_warn,
  output logic tx_warn,
  output logic irq
);
  import cecat_pkg::*;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  wire setup_ph = psel && !penable;
  wire acc_ph = psel && penable;
  wire wr_acc = acc_ph && pwrite && ce;
  wire hit_rx = hit(paddr, `CECAT_IDX_RXERR);
  wire hit_tx = hit(paddr, `CECAT_IDX_TXERR);
  wire hit_al = hit(paddr, `CECAT_IDX_ALPOS);
  wire hit_nbt = hit(paddr, `CECAT_IDX_NBT);
  wire hit_st = hit(paddr, `CECAT_IDX_IRQ_STAT);
  wire hit_en = hit(paddr, `CECAT_IDX_IRQ_EN);
  wire hit_clr = hit(paddr, `CECAT_IDX_IRQ_CLR);
  wire hit_ctl = hit(paddr, `CECAT_IDX_CTRL);
  wire mapped = hit_rx | hit_tx | hit_al | hit_nbt | hit_st | hit_en | hit_clr | hit_ctl;
  wire ro_wr = hit_rx | hit_tx | hit_al | hit_st;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [8:0] rec_r;
  logic [8:0] rec_nxt;
  logic [8:0] tec_r;
  logic [8:0] tec_nxt;
  logic [7:0] busfree_r;
  logic [7:0] busfree_nxt;
  cecat_fc_state_t fc_r;
  cecat_fc_state_t fc_nxt;
  cecat_nbt_t nbt_r;
  logic [3:0] irq_en_r;
  logic [3:0] irq_st_r;
  logic recover_req_r;
  logic al_flag;
  logic [5:0] al_pos;
  logic ext_sync;
  cecat_fc_ev_t ev;

  // extended-bit-time select is a pin-side level, passed through a two-flop synchroniser onto this clock
  assign ev = fc_ev;

  cecat_sync2 #(.W(1)) u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(extended_timing_select),
    .q(ext_sync)
  );

  wire al_clr = wr_acc && hit_clr && pwdata[`CECAT_STAT_AL];
  cecat_alcap u_alcap (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .arb_lost(arb_lost),
    .arb_pos(arb_pos),
    .flag_clr(al_clr),
    .flag(al_flag),
    .pos(al_pos)
  );

  // ----------------------------------------------------------------
  // fault confinement
  // ----------------------------------------------------------------
  function automatic logic [8:0] sat_add(input logic [8:0] v, input logic [3:0] n);
    logic [9:0] s;
    s = {1'b0, v} + {6'h00, n};
    sat_add = s[9] ? 9'h1ff : s[8:0];
  endfunction
  function automatic logic [8:0] dec1(input logic [8:0] v);
    dec1 = (v == 9'h000) ? 9'h000 : v - 9'h001;
  endfunction

  wire in_busoff = (fc_r == CECAT_BUSOFF);
  // an error while sending the error flag costs the transmitter the same +8
  wire tec_step = ev.tx_err | ev.tx_err_dom;

  always_comb begin
    rec_nxt = rec_r;
    tec_nxt = tec_r;
    busfree_nxt = busfree_r;
    fc_nxt = fc_r;
    case (fc_r)
      CECAT_ACTIVE, CECAT_PASSIVE: begin
        if (tec_step) begin
          tec_nxt = sat_add(tec_r, 4'h8);
        end else if (ev.tx_ok) begin
          tec_nxt = dec1(tec_r);
        end
        // receive error +1, dominant +8, success -1, or back to 119 from above 127
        if (ev.rx_err) begin
          rec_nxt = sat_add(rec_r, ev.rx_err_dom ? 4'h8 : 4'h1);
        end else if (ev.rx_ok) begin
          rec_nxt = (rec_r > 9'h07f) ? 9'h077 : dec1(rec_r);
        end
        if (tec_nxt >= `CECAT_BUSOFF_LIMIT) begin
          rec_nxt = `CECAT_CNT_RESET;
          tec_nxt = `CECAT_TEC_BUSOFF_LOAD;
          busfree_nxt = 8'h00;
          fc_nxt = CECAT_BUSOFF;
        end else if (tec_nxt >= `CECAT_PASSIVE_LIMIT || rec_nxt >= `CECAT_PASSIVE_LIMIT) begin
          fc_nxt = CECAT_PASSIVE;
        end else begin
          fc_nxt = CECAT_ACTIVE;
        end
      end
      CECAT_BUSOFF: begin
        if (recover_req_r && ev.bus_free) begin
          tec_nxt = dec1(tec_r);
          busfree_nxt = busfree_r + 8'h01;
          if (busfree_r == `CECAT_RECOVERY_BUSFREE - 8'h01) begin
            tec_nxt = `CECAT_CNT_RESET;
            rec_nxt = `CECAT_CNT_RESET;
            fc_nxt = CECAT_ACTIVE;
          end
        end
      end
      default: begin
        fc_nxt = CECAT_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_r <= `CECAT_CNT_RESET;
      tec_r <= `CECAT_CNT_RESET;
      busfree_r <= 8'h00;
      fc_r <= CECAT_ACTIVE;
    end else if (ce) begin
      rec_r <= rec_nxt;
      tec_r <= tec_nxt;
      busfree_r <= busfree_nxt;
      fc_r <= fc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  wire [3:0] ev_set = {fc_r == CECAT_BUSOFF && fc_nxt == CECAT_ACTIVE,
                       (rx_warn | tx_warn), fc_nxt == CECAT_BUSOFF && !in_busoff, arb_lost && !al_flag};
  wire [3:0] st_clr = (wr_acc && hit_clr) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbt_r <= `CECAT_NBT_RESET;
      irq_en_r <= 4'h0;
      irq_st_r <= 4'h0;
      recover_req_r <= 1'b0;
    end else if (ce) begin
      if (wr_acc && hit_nbt) begin
        nbt_r <= pwdata;
      end
      if (wr_acc && hit_en) begin
        irq_en_r <= pwdata[3:0];
      end
      // recovery only starts once software asks, as the protocol expects
      if (wr_acc && hit_ctl) begin
        recover_req_r <= pwdata[0];
      end else if (fc_r == CECAT_BUSOFF && fc_nxt == CECAT_ACTIVE) begin
        recover_req_r <= 1'b0;
      end
      // set wins over clear
      irq_st_r <= (irq_st_r & ~st_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    // live low byte of 9-bit counter
    if (hit_tx) rd_mux = {24'h000000, tec_r[7:0]};
    if (hit_rx) rd_mux = {24'h000000, rec_r[7:0]};
    if (hit_al) rd_mux = {26'h0000000, al_pos};
    if (hit_nbt) rd_mux = nbt_r;
    if (hit_st) rd_mux = {28'h0000000, irq_st_r};
    if (hit_en) rd_mux = {28'h0000000, irq_en_r};
    if (hit_ctl) rd_mux = {31'h00000000, recover_req_r};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      nom_timing <= '0;
      bus_off_flag <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      rx_warn <= 1'b0;
      tx_warn <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      // no wait state: answer registered from the setup cycle
      pready <= setup_ph;
      pslverr <= setup_ph && (!mapped || (pwrite && ro_wr));
      prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
      // fields active only in FD frames with extended timing
      nom_timing <= {nbt_r, fd_frame && ext_sync};
      bus_off_flag <= (fc_nxt == CECAT_BUSOFF);
      arbitration_lost_flag <= al_flag;
      rx_warn <= rec_nxt >= `CECAT_WARN_LIMIT;
      tx_warn <= tec_nxt >= `CECAT_WARN_LIMIT;
      irq <= |(((irq_st_r & ~st_clr) | ev_set) & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence enter_busoff_s;
    ce && !in_busoff && fc_nxt == CECAT_BUSOFF;
  endsequence
  busoff_rec_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    enter_busoff_s |=> rec_r == 9'h000) else $error("receive counter not cleared at bus-off");
  busoff_tec_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    enter_busoff_s |=> tec_r == 9'h07f && bus_off_flag) else $error("transmit counter not 127 at bus-off");
  recov_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && in_busoff && recover_req_r && ev.bus_free && busfree_r < 8'h7f && tec_r != 9'h000
    |=> tec_r == $past(tec_r) - 9'h001) else $error("recovery decrement missing");
  tec_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && hit_tx |=> prdata == {24'h000000, $past(tec_r[7:0])}) else $error("tx count read wrong");
  tec_wide_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_busoff |-> tec_r <= 9'h07f) else $error("counter exceeds 127 during recovery");
  al_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && hit_al |=> prdata[31:6] == 26'h0000000) else $error("alpos upper bits nonzero");
  nbt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_nbt |=> nbt_r == $past(pwdata)) else $error("timing write lost");
  timing_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !fd_frame |=> !nom_timing.active) else $error("nominal timing active outside fd");
  warn_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 1'b1 |-> tx_warn == (tec_r >= 9'h060) && rx_warn == (rec_r >= 9'h060))
    else $error("warning flag wrong");
endmodule // cecat_core

// file: rtl/cecat_pkg.sv
// types shared by the error-count and timing slice
package cecat_pkg;
  typedef struct packed {
    logic tx_ok;
    logic rx_ok;
    logic tx_err;
    logic tx_err_dom;
    logic rx_err;
    logic rx_err_dom;
    logic bus_free;
  } cecat_fc_ev_t;
  typedef struct packed {
    logic [6:0] sjw;
    logic [6:0] seg2;
    logic [7:0] seg1;
    logic [9:0] brp;
  } cecat_nbt_t;
  typedef struct packed {
    logic [6:0] sjw;
    logic [6:0] seg2;
    logic [7:0] seg1;
    logic [9:0] brp;
    logic active;
  } cecat_timing_t;
  typedef enum logic [2:0] {
    CECAT_ACTIVE = 3'b001,
    CECAT_PASSIVE = 3'b010,
    CECAT_BUSOFF = 3'b100
  } cecat_fc_state_t;
endpackage

// file: rtl/cecat_regs.svh
// register offsets, field positions, reset values and thresholds of the error-count slice
`ifndef CECAT_REGS_SVH
`define CECAT_REGS_SVH
// printed offsets are register indices; byte address is four times the index
`define CECAT_IDX_RXERR 8'h19
`define CECAT_IDX_TXERR 8'h1a
`define CECAT_IDX_ALPOS 8'h1b
`define CECAT_IDX_NBT 8'h1c
`define CECAT_IDX_IRQ_STAT 8'h30
`define CECAT_IDX_IRQ_EN 8'h31
`define CECAT_IDX_IRQ_CLR 8'h32
`define CECAT_IDX_CTRL 8'h33
`define CECAT_NBT_SJW_MSB 31
`define CECAT_NBT_SJW_LSB 25
`define CECAT_NBT_SEG2_MSB 24
`define CECAT_NBT_SEG2_LSB 18
`define CECAT_NBT_SEG1_MSB 17
`define CECAT_NBT_SEG1_LSB 10
`define CECAT_NBT_BRP_MSB 9
`define CECAT_NBT_BRP_LSB 0
`define CECAT_NBT_RESET 32'h0000_0000
`define CECAT_CNT_RESET 9'h000
`define CECAT_ALPOS_RESET 6'h00
`define CECAT_TEC_BUSOFF_LOAD 9'h07f
`define CECAT_WARN_LIMIT 9'h060
`define CECAT_PASSIVE_LIMIT 9'h080
`define CECAT_BUSOFF_LIMIT 9'h100
`define CECAT_RECOVERY_BUSFREE 8'h80
`define CECAT_STAT_AL 0
`define CECAT_STAT_BUSOFF 1
`define CECAT_STAT_WARN 2
`define CECAT_STAT_REC 3
`endif

// file: rtl/cecat_sync2.sv
// two-flop synchroniser for pin-side levels
`timescale 1ns/1ps
module cecat_sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // cecat_sync2

// file: testbench/can_error_count_arbitration_timing_test.sv
// self-checking bench for the error counters, arbitration capture and nominal timing
`timescale 1ns/1ps
module can_error_count_arbitration_timing_test;
  import cecat_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fd_frame, ext_sel;
  logic arb_lost, bus_off_flag, al_flag, rx_warn, tx_warn, irq, er, ce;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [7:0] ev_req;
  logic [5:0] pos_req, arb_pos, p1;
  cecat_fc_ev_t fc_ev;
  cecat_timing_t nom_timing;
  int err_count, checked, tec, rec;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  cecat_frame_model cecat_frame_model_inst (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
    .pos_req(pos_req), .fc_ev(fc_ev), .arb_lost(arb_lost), .arb_pos(arb_pos));
  cecat_core cecat_core_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fc_ev(fc_ev), .arb_lost(arb_lost), .arb_pos(arb_pos), .fd_frame(fd_frame),
    .extended_timing_select(ext_sel), .nom_timing(nom_timing), .bus_off_flag(bus_off_flag),
    .arbitration_lost_flag(al_flag), .rx_warn(rx_warn), .tx_warn(tx_warn), .irq(irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so a following call never re-drives psel in this time step
    @(posedge pclk);
    if (n >= 20) begin
      err_count++;
      $display("ERROR %0t: no ready", $time);
      close_out;
    end
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(er, 1'b0);
  endtask
  task automatic ev(input logic [7:0] e, input logic [5:0] p);
    ev_req <= e;
    pos_req <= p;
    @(posedge pclk);
    ev_req <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic txe;
    ev(8'h10, 6'h00);
    tec += 8;
    if (tec > 255) begin
      tec = 127;
      rec = 0;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev_req, pos_req, fd_frame, ext_sel} = '0;
    presetn = 1'b0;
    ce = 1'b1;
    err_count = 0;
    checked = 0;
    tec = 0;
    rec = 0;
    void'($urandom(63016));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rchk(10'h064 + 10'(4 * i), 32'h0);
    $display("reset values done");
    v = $urandom;
    apb(1'b1, 10'h070, v);
    rchk(10'h070, v);
    for (int i = 0; i < 4; i++) begin
      fd_frame <= i[0];
      ext_sel <= i[1];
      repeat (5) @(posedge pclk);
      chk(nom_timing[32:1], v);
      chk(nom_timing.active, i[0] & i[1]);
    end
    $display("timing done");
    apb(1'b0, 10'h074, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 10'h064, 32'h55);
    chk(er, 1'b1);
    rchk(10'h064, 32'h0);
    $display("refusals done");
    repeat (5) ev(8'h04, 6'h00);
    ev(8'h06, 6'h00);
    rec = 13;
    rchk(10'h064, rec);
    for (int i = 0; i < 12; i++) txe;
    chk(tx_warn, 1'b1);
    ev(8'h40, 6'h00);
    tec--;
    chk(tx_warn, 1'b0);
    rchk(10'h068, tec);
    // an error pulse while the enable is low must leave the counter alone
    ce <= 1'b0;
    ev(8'h10, 6'h00);
    ce <= 1'b1;
    rchk(10'h068, tec);
    // the model clears its receive count on bus-off entry
    for (int i = 0; i < 40 && rec != 0; i++) txe;
    rchk(10'h068, 32'd127);
    rchk(10'h064, 32'h0);
    chk(bus_off_flag, 1'b1);
    $display("bus-off entry done");
    apb(1'b1, 10'h0cc, 32'h1);
    repeat (10) ev(8'h01, 6'h00);
    rchk(10'h068, 32'd117);
    repeat (117) ev(8'h01, 6'h00);
    chk(bus_off_flag, 1'b1);
    ev(8'h01, 6'h00);
    chk(bus_off_flag, 1'b0);
    rchk(10'h068, 32'h0);
    $display("recovery done");
    p1 = 6'($urandom);
    ev(8'h80, p1);
    ev(8'h80, p1 ^ 6'h2a);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rchk(10'h06c, {26'h0, p1});
    rchk(10'h0c0, 32'hf);
    apb(1'b1, 10'h0c4, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 10'h0c8, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    chk(al_flag, 1'b0);
    ev(8'h80, p1 ^ 6'h15);
    rchk(10'h06c, {26'h0, p1 ^ 6'h15});
    $display("arbitration capture done");
    for (int i = 0; i < 12; i++) begin
      ev(8'h06, 6'h00);
      rec += 8;
    end
    chk(rx_warn, 1'b1);
    rchk(10'h064, rec);
    ev(8'h20, 6'h00);
    rec--;
    chk(rx_warn, 1'b0);
    rchk(10'h064, rec);
    $display("receive warning done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    tec = 0;
    rec = 0;
    for (int i = 0; i < 4; i++) rchk(10'h064 + 10'(4 * i), 32'h0);
    chk({rx_warn, tx_warn, irq, al_flag}, 4'h0);
    $display("mid-run reset done");
    close_out;
  end
  initial begin
    #1000000;
    err_count++;
    $display("ERROR %0t: run too long", $time);
    close_out;
  end
endmodule // can_error_count_arbitration_timing_test

// file: testbench/cecat_frame_model.sv
// frame engine stand-in: turns bench requests into one-cycle event pulses
`timescale 1ns/1ps
module cecat_frame_model
  import cecat_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] ev_req,
  input wire logic [5:0] pos_req,
  output cecat_pkg::cecat_fc_ev_t fc_ev,
  output logic arb_lost,
  output logic [5:0] arb_pos
);
  // position is only valid with the pulse; otherwise it toggles so a stale value is never trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_ev <= '0;
      arb_lost <= 1'b0;
      arb_pos <= 6'h00;
    end else begin
      fc_ev <= ev_req[6:0];
      arb_lost <= ev_req[7];
      arb_pos <= ev_req[7] ? pos_req : ~arb_pos;
    end
  end
endmodule // cecat_frame_model
